// ==== rtl/csr_pkg.sv ====
/*
 Shared constants for the clocked static RAM core: geometry, variant codes
 and internal phase timing counts.
 Assumes a single 100 MHz system clock.
*/
package csr_pkg;
   localparam int ROW_BITS = 6;
   localparam int ROWS = 64;
   localparam int ADDR_BITS = 10;
   localparam int COL_BITS_WIDE = 4;
   localparam int COL_BITS_NARROW = 6;
   localparam int COLS_PER_PAIR_WIDE = 16;
   localparam int COLS_NARROW = 64;
   localparam int DATA_W = 4;
   // Variant select: 1 = 1024x4 common I/O, 0 = 4096x1 separate I/O
   localparam bit WIDE_DEFAULT = 1'b1;
   // Clock period and modelled internal delays
   localparam int CLK_NS = 10;
   localparam int REF_ROW_NS = 30;
   localparam int REF_ROW_CYC = (REF_ROW_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRESET_NS = 20;
   localparam int PRESET_CYC = (PRESET_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] DATA_RST = 4'h0;
   typedef enum logic [3:0] {
      CSR_PRESET = 4'b0001,
      CSR_DECODE = 4'b0010,
      CSR_FIRE = 4'b0100,
      CSR_VALID = 4'b1000
   } csr_phase_t;
endpackage

// ==== rtl/csr_arr_if.sv ====
/*
 Interface carrying row fire, column and data between the core control and
 its cell array.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface csr_arr_if;
   logic [63:0] row_sel;
   logic [5:0] col;
   logic wide;
   logic wr_en;
   logic [3:0] wr_data;
   logic [3:0] rd_data;
   modport ctrl (output row_sel, output col, output wide, output wr_en, output wr_data,
      input rd_data);
   modport arr (input row_sel, input col, input wide, input wr_en, input wr_data,
      output rd_data);
endinterface
`default_nettype wire

// ==== rtl/csr_cell_array.sv ====
/*
 Cell array: 64 rows, 64 bit columns, addressed by one-hot row select and
 a column number; read data leave through a register.
 Assumes at most one row select is high.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_cell_array (
   input wire logic i_clk,
   csr_arr_if.arr arr
);
   logic [63:0] cells [64];
   logic [63:0] row_word;
   logic row_any;

   // Pick the selected row; isolated cells give nothing
   always_comb begin
      row_word = '0;
      row_any = 1'b0;
      for (int r = 0; r < 64; r++) begin
         if (arr.row_sel[r]) begin
            row_word = row_word | cells[r];
            row_any = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      for (int r = 0; r < 64; r++) begin
         if (arr.row_sel[r] && arr.wr_en) begin
            if (arr.wide) begin
               for (int b = 0; b < 4; b++) begin
                  cells[r][b*16 + int'(arr.col[3:0])] <= arr.wr_data[b];
               end
            end else begin
               cells[r][arr.col] <= arr.wr_data[0];
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!row_any) begin
         arr.rd_data <= 4'h0;
      end else if (arr.wide) begin
         for (int b = 0; b < 4; b++) begin
            arr.rd_data[b] <= row_word[b*16 + int'(arr.col[3:0])];
         end
      end else begin
         arr.rd_data <= {3'h0, row_word[arr.col]};
      end
   end
endmodule
`default_nettype wire

// ==== rtl/csr_row_decoder.sv ====
/*
 One row decoder with its driver and holding latch.
 Assumes the decode bus is held all-low during preset.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_row_decoder #(
   parameter logic [5:0] ROW_ID = 6'h00
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [5:0] i_x_true,
   input wire logic [5:0] i_x_comp,
   input wire logic i_fire,
   output var logic o_sel
);
   logic [5:0] taps;
   logic driver_on;

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         taps[i] = ROW_ID[i] ? i_x_comp[i] : i_x_true[i];
      end
   end

   assign driver_on = ~|taps;

   // holding latch, set by select, low when driver off
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sel <= 1'b0;
      end else begin
         o_sel <= driver_on & i_fire;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/csr_core.sv ====
/*
 Clocked static RAM core: address register, row decode, reference row
 timing, output register and enables, write gating and ready indicator.
 Assumes a control master that obeys the ready indicator handshake and
 drives pins that may be asynchronous to I_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Six row bits feed 64 decoders.
// - Exactly one decoder enables its driver outside preset; all 64 do in preset.
// - Row fire raises only the selected row.
// - Preset holds decode inputs and fire low.
// - Each row select has holding latch.
// - Cells isolated unless row selected.
// - 64 cells per column; 16 per pair.
// - Equalizer runs only during preset.
// - Assist latch enabled by access timing.
// - Reference row fires every cycle.
// - Column decode not gated by fire.
// - Output register holds while strobe low.
// - Rising strobe blanks output until access.
// - Latched chip select high disables output.
// - Output needs allow high, block low.
// - Write needs select, strobe high, write low.
// - Write strobe never touches output enable.
// - Wide variant shares data pins.
// - Ready follows access timing through replica.
// - Ready always driven, even unselected.
// - Address captured at strobe rise.
// - Ready rise marks valid data.
// - Ready fall marks preset end.
module csr_core #(
   parameter bit WIDE = csr_pkg::WIDE_DEFAULT,
   parameter int REF_CYC = csr_pkg::REF_ROW_CYC,
   parameter int PRE_CYC = csr_pkg::PRESET_CYC
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_CYCLE_STROBE,
   input wire logic I_CHIP_SEL_N,
   input wire logic I_OUTPUT_ALLOW,
   input wire logic I_OUTPUT_BLOCK,
   input wire logic I_WRITE_N,
   input wire logic [csr_pkg::ADDR_BITS-1:0] I_ADDR,
   input wire logic [csr_pkg::DATA_W-1:0] I_DATA,
   output logic [csr_pkg::DATA_W-1:0] O_DATA,
   output logic [csr_pkg::DATA_W-1:0] O_DATA_OE,
   output logic O_READY_INDICATOR,
   output logic O_BIT_LINE_EQUALIZER,
   output logic O_BIT_LINE_ASSIST_LATCH
);
   import csr_pkg::*;

   csr_arr_if arr_bus ();

   logic [2:0] strb_s;
   logic [2:0] cs_s;
   logic [2:0] allow_s;
   logic [2:0] block_s;
   logic [2:0] wr_s;
   logic strobe;
   logic chip_sel_n;
   logic allow;
   logic block;
   logic write_n;
   logic [ADDR_BITS-1:0] addr_d1;
   logic [ADDR_BITS-1:0] addr_d2;
   logic [DATA_W-1:0] data_d1;
   logic [DATA_W-1:0] data_d2;
   csr_phase_t phase;
   csr_phase_t next_phase;
   logic [ADDR_BITS-1:0] addr_reg;
   logic cs_latched_n;
   logic [5:0] x_true;
   logic [5:0] x_comp;
   logic row_fire_clock;
   logic [63:0] row_sel;
   logic [7:0] ref_cnt;
   logic [7:0] pre_cnt;
   logic access_timing;
   logic [DATA_W-1:0] out_reg;
   logic ready_replica;
   logic replica_line;
   logic [DATA_W-1:0] data_reg;
   logic rise;
   logic fall;

   // Pin synchronisers: change counts when stages two and three agree
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         strb_s <= 3'h0;
         cs_s <= 3'h7;
         allow_s <= 3'h0;
         block_s <= 3'h0;
         wr_s <= 3'h7;
      end else begin
         strb_s <= {strb_s[1:0], I_CYCLE_STROBE};
         cs_s <= {cs_s[1:0], I_CHIP_SEL_N};
         allow_s <= {allow_s[1:0], I_OUTPUT_ALLOW};
         block_s <= {block_s[1:0], I_OUTPUT_BLOCK};
         wr_s <= {wr_s[1:0], I_WRITE_N};
      end
   end

   // Agreed level of the cycle strobe
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         strobe <= 1'b0;
      end else if (strb_s[1] == strb_s[2]) begin
         strobe <= strb_s[2];
      end
   end

   // Agreed level of the chip select
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         chip_sel_n <= 1'b1;
      end else if (cs_s[1] == cs_s[2]) begin
         chip_sel_n <= cs_s[2];
      end
   end

   // Agreed level of output allow
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         allow <= 1'b0;
      end else if (allow_s[1] == allow_s[2]) begin
         allow <= allow_s[2];
      end
   end

   // Agreed level of output block
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         block <= 1'b0;
      end else if (block_s[1] == block_s[2]) begin
         block <= block_s[2];
      end
   end

   // Agreed level of the write strobe
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         write_n <= 1'b1;
      end else if (wr_s[1] == wr_s[2]) begin
         write_n <= wr_s[2];
      end
   end

   // Address and data pipes, two stages against four on the strobe path
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         addr_d1 <= '0;
         addr_d2 <= '0;
         data_d1 <= DATA_RST;
         data_d2 <= DATA_RST;
      end else begin
         addr_d1 <= I_ADDR;
         addr_d2 <= addr_d1;
         data_d1 <= I_DATA;
         data_d2 <= data_d1;
      end
   end

   assign rise = strobe & (phase == CSR_PRESET) & (pre_cnt == 8'h00);
   assign fall = ~strobe;

   // Phase sequencing of one memory cycle
   always_comb begin
      next_phase = phase;
      unique case (phase)
         CSR_PRESET: begin
            if (rise) next_phase = CSR_DECODE;
         end
         CSR_DECODE: begin
            if (fall) next_phase = CSR_PRESET;
            else next_phase = CSR_FIRE;
         end
         CSR_FIRE: begin
            if (fall) next_phase = CSR_PRESET;
            else if (ref_cnt == 8'(REF_CYC - 1)) next_phase = CSR_VALID;
         end
         CSR_VALID: begin
            if (fall) next_phase = CSR_PRESET;
         end
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         phase <= CSR_PRESET;
      end else begin
         phase <= next_phase;
      end
   end

   // address and chip select captured at strobe rise
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         addr_reg <= '0;
         cs_latched_n <= 1'b1;
      end else if (rise) begin
         addr_reg <= addr_d2;
         cs_latched_n <= chip_sel_n;
      end
   end

   // write data held from cycle start; the data pipe is shorter than the strobe path
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         data_reg <= DATA_RST;
      end else if (rise) begin
         data_reg <= data_d2;
      end
   end

   always_comb begin
      if (phase == CSR_PRESET) begin
         x_true = 6'h00;
         x_comp = 6'h00;
      end else begin
         x_true = addr_reg[ROW_BITS-1:0];
         x_comp = ~addr_reg[ROW_BITS-1:0];
      end
   end

   // row fire follows the bit-5 transition; low in preset
   assign row_fire_clock = (phase == CSR_FIRE || phase == CSR_VALID) & (x_true[5] | x_comp[5]);

   for (genvar r = 0; r < ROWS; r++) begin : g_row
      csr_row_decoder #(.ROW_ID(6'(r))) u_dec (
         .i_clk(I_CLK),
         .i_rst(I_SYS_RST),
         .i_x_true(x_true),
         .i_x_comp(x_comp),
         .i_fire(row_fire_clock),
         .o_sel(row_sel[r])
      );
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ref_cnt <= 8'h00;
      end else if (phase == CSR_FIRE) begin
         ref_cnt <= ref_cnt + 8'h01;
      end else begin
         ref_cnt <= 8'h00;
      end
   end

   // Preset length counted after strobe falls
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pre_cnt <= 8'h00;
      end else if (phase != CSR_PRESET) begin
         pre_cnt <= 8'(PRE_CYC);
      end else if (pre_cnt != 8'h00) begin
         pre_cnt <= pre_cnt - 8'h01;
      end
   end

   assign access_timing = (phase == CSR_VALID);

   // ten address bits, row then column
   // column from address, not gated by fire
   assign arr_bus.col = WIDE ? {2'h0, addr_reg[9:6]} : addr_reg[9:4];
   assign arr_bus.row_sel = row_sel;
   assign arr_bus.wide = WIDE;
   // write gating; wide data from shared pins
   assign arr_bus.wr_en = ~cs_latched_n & strobe & (phase != CSR_PRESET) & ~write_n;
   assign arr_bus.wr_data = WIDE ? data_reg : {3'h0, data_reg[0]};

   csr_cell_array u_arr (
      .i_clk(I_CLK),
      .arr(arr_bus)
   );

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         out_reg <= DATA_RST;
      end else if (rise) begin
         out_reg <= DATA_RST;
      end else if (access_timing && strobe) begin
         out_reg <= arr_bus.wr_en ? arr_bus.wr_data : arr_bus.rd_data;
      end
   end

   assign O_DATA = out_reg;

   // blank at rise; chip select; allow and block
   // write strobe deliberately absent from the enable
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_DATA_OE <= 4'h0;
      end else if (rise || phase == CSR_DECODE || phase == CSR_FIRE) begin
         O_DATA_OE <= 4'h0;
      end else if (!cs_latched_n && allow && !block && out_valid_seen()) begin
         O_DATA_OE <= WIDE ? 4'hf : 4'h1;
      end else begin
         O_DATA_OE <= 4'h0;
      end
   end

   function automatic logic out_valid_seen();
      return access_timing | ready_replica;
   endfunction

   // pseudo data line, precharged in preset like the real pairs
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         replica_line <= 1'b0;
      end else begin
         replica_line <= (next_phase == CSR_VALID);
      end
   end

   // ready via replica register; falls after preset
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ready_replica <= 1'b0;
      end else if (access_timing && replica_line) begin
         ready_replica <= 1'b1;
      end else if (phase == CSR_PRESET && pre_cnt == 8'h01) begin
         ready_replica <= 1'b0;
      end
   end

   // always driven; rise with valid data
   assign O_READY_INDICATOR = ready_replica;

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_BIT_LINE_EQUALIZER <= 1'b1;
      end else begin
         O_BIT_LINE_EQUALIZER <= (next_phase == CSR_PRESET);
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_BIT_LINE_ASSIST_LATCH <= 1'b0;
      end else begin
         O_BIT_LINE_ASSIST_LATCH <= (next_phase == CSR_VALID);
      end
   end
endmodule
`default_nettype wire

// ==== bench/csr_core_chk.sv ====
/*
 Port checker for csr_core: strobe, ready, output enable and phase flags.
 Assumes chip select, allow and block change only between cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_core_chk #(
   parameter int REF_CYC = 3,
   parameter int PRE_CYC = 2
) (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_CYCLE_STROBE,
   input wire logic I_CHIP_SEL_N,
   input wire logic I_OUTPUT_ALLOW,
   input wire logic I_OUTPUT_BLOCK,
   input wire logic [csr_pkg::DATA_W-1:0] O_DATA,
   input wire logic [csr_pkg::DATA_W-1:0] O_DATA_OE,
   input wire logic O_READY_INDICATOR,
   input wire logic O_BIT_LINE_EQUALIZER,
   input wire logic O_BIT_LINE_ASSIST_LATCH
);
   import csr_pkg::*;
   localparam int RMAX = REF_CYC + 6;
   localparam int FMAX = PRE_CYC + 6;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   // Access timing and output blanking
   property p_blank;
      $rose(I_CYCLE_STROBE) |-> ##5 (O_DATA_OE == 4'h0) [*2];
   endproperty
   a_blank: assert property (p_blank) else $error("output on before access");
   property p_rdy;
      $rose(I_CYCLE_STROBE) && !O_READY_INDICATOR |->
         !O_READY_INDICATOR [*6] ##[1:RMAX] O_READY_INDICATOR;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready late or early");
   property p_fall;
      $fell(I_CYCLE_STROBE) && O_READY_INDICATOR |->
         O_READY_INDICATOR [*3] ##[1:FMAX] !O_READY_INDICATOR;
   endproperty
   a_fall: assert property (p_fall) else $error("ready fall out of window");
   property p_hold;
      $fell(I_CYCLE_STROBE) && O_READY_INDICATOR |=> $stable(O_DATA) [*5];
   endproperty
   a_hold: assert property (p_hold) else $error("output data moved in preset");
   property p_assist;
      $rose(O_READY_INDICATOR) |-> $past(O_BIT_LINE_ASSIST_LATCH);
   endproperty
   a_assist: assert property (p_assist) else $error("ready without access timing");
   property p_equ;
      !I_CYCLE_STROBE [*8] |-> O_BIT_LINE_EQUALIZER && !O_BIT_LINE_ASSIST_LATCH;
   endproperty
   a_equ: assert property (p_equ) else $error("equalizer off in preset");
   // Output enable conditions
   property p_allow;
      !I_OUTPUT_ALLOW [*6] |-> O_DATA_OE == 4'h0;
   endproperty
   a_allow: assert property (p_allow) else $error("output on while not allowed");
   property p_block;
      I_OUTPUT_BLOCK [*6] |-> O_DATA_OE == 4'h0;
   endproperty
   a_block: assert property (p_block) else $error("output on while blocked");
   property p_cs;
      I_CHIP_SEL_N && $rose(I_CYCLE_STROBE) |-> ##10 (O_DATA_OE == 4'h0) [*3];
   endproperty
   a_cs: assert property (p_cs) else $error("output on while unselected");
   c_rdy: cover property ($rose(O_READY_INDICATOR));
   c_oe: cover property (O_DATA_OE == 4'hf);
   c_unsel: cover property (I_CHIP_SEL_N && $rose(O_READY_INDICATOR));
endmodule
bind csr_core csr_core_chk #(.REF_CYC(REF_CYC), .PRE_CYC(PRE_CYC)) u_chk (
   .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CYCLE_STROBE(I_CYCLE_STROBE),
   .I_CHIP_SEL_N(I_CHIP_SEL_N), .I_OUTPUT_ALLOW(I_OUTPUT_ALLOW),
   .I_OUTPUT_BLOCK(I_OUTPUT_BLOCK), .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE),
   .O_READY_INDICATOR(O_READY_INDICATOR), .O_BIT_LINE_EQUALIZER(O_BIT_LINE_EQUALIZER),
   .O_BIT_LINE_ASSIST_LATCH(O_BIT_LINE_ASSIST_LATCH));
`default_nettype wire

// ==== bench/csr_ctl_model.sv ====
/*
 Memory control model: runs one strobe cycle per call, paced by ready.
 Assumes a free-running clock; drives on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_ctl_model (
   input wire logic i_clk,
   input wire logic i_ready,
   output logic o_strobe,
   output logic o_write_n,
   output logic [csr_pkg::ADDR_BITS-1:0] o_addr,
   output logic [csr_pkg::DATA_W-1:0] o_data
);
   import csr_pkg::*;
   // Idle levels
   initial begin
      o_strobe = 1'b0;
      o_write_n = 1'b1;
      o_addr = 10'h000;
      o_data = 4'h0;
   end
   // One access, held slow or prompt by hold
   task automatic access(input logic wr, input logic [9:0] a, input logic [3:0] d,
      input int hold);
      int n;
      n = 0;
      while (i_ready !== 1'b0 && n < 50) begin
         @(negedge i_clk);
         n++;
      end
      @(negedge i_clk);
      o_addr = a;
      o_data = d;
      o_write_n = !wr;
      o_strobe = 1'b1;
      n = 0;
      while (i_ready !== 1'b1 && n < 50) begin
         @(negedge i_clk);
         n++;
      end
      repeat (hold) @(negedge i_clk);
      o_strobe = 1'b0;
      o_write_n = 1'b1;
      o_addr = ~a;
      o_data = ~d;
   endtask
endmodule
`default_nettype wire

// ==== bench/clocked_static_ram_core_tb.sv ====
/*
 Self-checking bench for csr_core, wide variant, with a control model.
 Assumes the package defaults and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module clocked_static_ram_core_tb;
   import csr_pkg::*;
   typedef struct {logic [3:0] data; logic [3:0] oe; bit dchk;} csr_exp_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n = 1'b0;
   logic allow = 1'b1;
   logic block = 1'b0;
   logic strobe, write_n, ready, equ, assist;
   logic rdy_seen = 1'b0;
   logic [9:0] addr;
   logic [3:0] din, dout, oe;
   logic [3:0] mem [1024];
   logic [9:0] corner [4] = '{10'h000, 10'h3ff, 10'h03f, 10'h3c0};
   csr_exp_t q [$];
   csr_exp_t exp;
   int miscompares = 0;
   int checks = 0;
   always #5 clk = ~clk;
   csr_core uut (.I_CLK(clk), .I_SYS_RST(rst), .I_CYCLE_STROBE(strobe),
      .I_CHIP_SEL_N(cs_n), .I_OUTPUT_ALLOW(allow), .I_OUTPUT_BLOCK(block),
      .I_WRITE_N(write_n), .I_ADDR(addr), .I_DATA(din), .O_DATA(dout), .O_DATA_OE(oe),
      .O_READY_INDICATOR(ready), .O_BIT_LINE_EQUALIZER(equ),
      .O_BIT_LINE_ASSIST_LATCH(assist));
   csr_ctl_model u_ctl (.i_clk(clk), .i_ready(ready), .o_strobe(strobe),
      .o_write_n(write_n), .o_addr(addr), .o_data(din));
   task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic rst_chk;
      chk("dout", 4'h0, dout);
      chk("oe", 4'h0, oe);
      chk("flags", 4'h2, {1'b0, ready, equ, assist});
   endtask
   // Note the expected result, then run the access
   task automatic cyc(input logic wr, input logic [9:0] a, input logic [3:0] d);
      csr_exp_t e;
      e.oe = (!cs_n && allow && !block) ? 4'hf : 4'h0;
      e.data = wr ? d : mem[a];
      e.dchk = !cs_n;
      if (wr && !cs_n) begin
         mem[a] = d;
      end
      q.push_back(e);
      u_ctl.access(wr, a, d, $urandom_range(0, 4));
   endtask
   // Compare each completed access with the oldest note
   always @(negedge clk) begin
      if (ready === 1'b1 && rdy_seen === 1'b0 && q.size() > 0) begin
         exp = q.pop_front();
         if (exp.dchk) chk("data", exp.data, dout);
         chk("oe", exp.oe, oe);
      end
      rdy_seen = ready;
   end
   // Main sequence
   initial begin
      logic [9:0] wa [$];
      logic [9:0] a;
      void'($urandom(1228));
      repeat (10) @(negedge clk);
      rst = 1'b0;
      rst_chk();
      for (int i = 0; i < 20; i++) begin
         a = (i < 4) ? corner[i] : 10'($urandom_range(0, 1023));
         wa.push_back(a);
         cyc(1'b1, a, 4'($urandom));
      end
      foreach (wa[i]) begin
         {allow, block} = 2'(i);
         cyc(1'b0, wa[i], 4'h0);
      end
      {allow, block} = 2'b10;
      cs_n = 1'b1;
      cyc(1'b1, wa[0], ~mem[wa[0]]);
      cs_n = 1'b0;
      cyc(1'b0, wa[0], 4'h0);
      // Reset in mid-run
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      rst_chk();
      cyc(1'b1, 10'h2a5, 4'h9);
      cyc(1'b0, 10'h2a5, 4'h0);
      repeat (20) @(negedge clk);
      chk("pending", 4'h0, 4'(q.size()));
      conclude();
   end
   // Watchdog
   initial begin
      #200us;
      miscompares++;
      conclude();
   end
endmodule
`default_nettype wire
